// [hrg_pkg.sv]
package hrg_pkg;

  localparam int unsigned RAW_BITS = 1;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned STATE_W = 64;

  // Total-failure test: a run of identical raw bits two longer than this (34) is a dead source.
  localparam logic [7:0] STUCK_LIMIT = 8'h20;
  // Online test window and tolerated ones count band (monobit).
  localparam logic [7:0] WIN_LEN = 8'hff;
  localparam logic [7:0] ONES_LO = 8'h50;
  localparam logic [7:0] ONES_HI = 8'hb0;
  // Entropy estimator: transitions per window select the compression ratio.
  localparam logic [7:0] TRANS_GOOD = 8'h60;
  localparam logic [3:0] RATIO_LOW = 4'h2;
  localparam logic [3:0] RATIO_HIGH = 4'h4;
  // Compressed bits needed for the seed and for each output word.
  localparam logic [7:0] SEED_BITS = 8'h80;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [4:0] HALF_BITS = 5'h10;

  localparam logic [STATE_W-1:0] STATE_RST = 64'h0;
  localparam logic [STATE_W-1:0] MIX_K = 64'h9e3779b97f4a7c15;

  typedef struct packed {
    logic wide;
    logic [WORD_W-1:0] data;
  } hrg_word_t;

  typedef enum logic [1:0] {
    ST_TEST,
    ST_SEED,
    ST_RUN,
    ST_FAIL
  } hrg_state_t;

endpackage

// [hrg_fifo.sv]
`timescale 1ns/1ns
module hrg_fifo #(
  parameter int unsigned WIDTH = 17,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;

  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

// [hrg_top.sv]
// Behaviour
// (R1) Total-failure test runs from start; once failed, no output ever.
// (R2) Words built from raw bits after failure are discarded.
// (R3) Online test checks raw bits at startup and during operation.
// (R4) Output blocked until startup test and seeding complete, or on defect.
// (R5) Online test scans every raw bit, never sampling.
// (R6) Post-processor emits no more bits than it consumes.
// (R7) Post-processor is deterministic, with nonlinear update and output.
// (R8) Words delivered as 8 or 16 bits.
// (R9) Post-processor input comes only from the tested physical source.
// (R10) Raw bits compressed with ratio chosen by an entropy estimator.
// (R11) Compression ratio kept high enough for near-full entropy per byte.
// (R12) Valid accompanies each word and stays low while output is blocked.
`timescale 1ns/1ns
module hrg_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic raw_bit,
  input wire logic raw_strobe,
  input wire logic wide_mode,
  output logic [hrg_pkg::WORD_W-1:0] rnd_data,
  output logic rnd_wide,
  output logic rnd_valid,
  input wire logic rnd_ready,
  output logic ready_state,
  output logic fail_total,
  output logic fail_online
);

  ////////////////////////////////////////
  // Synchronisers for the physical source pins.

  logic bit_s1;
  logic bit_s2;
  logic stb_s1;
  logic stb_s2;
  logic stb_s3;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_s1 <= 1'b0;
      bit_s2 <= 1'b0;
      stb_s1 <= 1'b0;
      stb_s2 <= 1'b0;
      stb_s3 <= 1'b0;
    end else begin
      bit_s1 <= raw_bit;
      bit_s2 <= bit_s1;
      stb_s1 <= raw_strobe;
      stb_s2 <= stb_s1;
      stb_s3 <= stb_s2;
    end
  end

  wire raw_new = stb_s2 && !stb_s3;

  ////////////////////////////////////////
  // Total-failure and online tests on every raw bit.

  hrg_pkg::hrg_state_t state;
  hrg_pkg::hrg_state_t next_state;
  logic last_bit;
  logic [7:0] run_len;
  logic [7:0] win_cnt;
  logic [7:0] ones_cnt;
  logic [7:0] trans_cnt;
  logic [3:0] ratio;
  logic test_passed;

  wire same_bit = (bit_s2 == last_bit);
  wire stuck = raw_new && same_bit && (run_len >= hrg_pkg::STUCK_LIMIT);
  wire win_end = raw_new && (win_cnt == hrg_pkg::WIN_LEN);
  wire [8:0] ones_sum = {1'b0, ones_cnt} + {8'h00, bit_s2};
  wire ones_bad = (ones_sum < {1'b0, hrg_pkg::ONES_LO}) ||
                  (ones_sum > {1'b0, hrg_pkg::ONES_HI});
  wire online_bad = win_end && ones_bad;
  wire defect = stuck || online_bad || fail_total || fail_online;
  wire next_ratio_good = trans_cnt >= hrg_pkg::TRANS_GOOD;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_bit <= 1'b0;
      run_len <= 8'h00;
      win_cnt <= 8'h00;
      ones_cnt <= 8'h00;
      trans_cnt <= 8'h00;
      ratio <= hrg_pkg::RATIO_HIGH;
      test_passed <= 1'b0;
    end else if (raw_new) begin // see (R5)
      last_bit <= bit_s2;
      run_len <= same_bit ? run_len + 8'h01 : 8'h00; // see (R1)
      win_cnt <= win_end ? 8'h00 : win_cnt + 8'h01; // see (R3)
      ones_cnt <= win_end ? 8'h00 : ones_cnt + {7'h00, bit_s2};
      trans_cnt <= win_end ? 8'h00 : trans_cnt + {7'h00, !same_bit};
      if (win_end) begin
        ratio <= next_ratio_good ? hrg_pkg::RATIO_LOW
                                 : hrg_pkg::RATIO_HIGH; // see (R10) (R11)
        test_passed <= !ones_bad; // see (R3)
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fail_total <= 1'b0;
      fail_online <= 1'b0;
    end else begin
      if (stuck) begin
        fail_total <= 1'b1; // see (R1)
      end
      if (online_bad) begin
        fail_online <= 1'b1; // see (R3)
      end
    end
  end

  ////////////////////////////////////////
  // Adaptive compression: XOR a number of raw bits into one output bit.

  logic [3:0] fold_cnt;
  logic fold_acc;
  wire fold_last = raw_new && (fold_cnt == ratio - 4'h1);
  wire comp_bit = fold_acc ^ bit_s2;
  wire comp_valid = fold_last && !defect; // see (R2) (R9)

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fold_cnt <= 4'h0;
      fold_acc <= 1'b0;
    end else if (raw_new) begin
      fold_cnt <= fold_last ? 4'h0 : fold_cnt + 4'h1; // see (R10)
      fold_acc <= fold_last ? 1'b0 : comp_bit;
    end
  end

  ////////////////////////////////////////
  // Deterministic post-processor, seeded and credited by compressed bits.

  logic [hrg_pkg::STATE_W-1:0] dstate;
  logic [7:0] seed_cnt;
  logic [4:0] credit;
  logic [hrg_pkg::WORD_W-1:0] acc;
  logic acc_wide;

  wire [4:0] need = wide_mode ? hrg_pkg::HALF_BITS : hrg_pkg::BYTE_BITS;
  wire [hrg_pkg::STATE_W-1:0] rot = {dstate[40:0], dstate[63:41]};
  wire [hrg_pkg::STATE_W-1:0] mixed = (rot ^ hrg_pkg::MIX_K) +
                                      (dstate & {dstate[62:0], comp_bit});
  wire [hrg_pkg::STATE_W-1:0] next_dstate = mixed ^
                                            {63'h0, comp_bit & comp_valid};
  wire [hrg_pkg::WORD_W-1:0] out_fn = dstate[63:48] ^ dstate[31:16] ^
                                      (dstate[47:32] & dstate[15:0]);
  wire credit_full = credit >= need;
  wire fifo_in_ready;
  wire make_word = (state == hrg_pkg::ST_RUN) && credit_full &&
                   fifo_in_ready && !defect; // see (R6)
  wire seed_done = seed_cnt >= hrg_pkg::SEED_BITS;
  wire run_bit = comp_valid && (state == hrg_pkg::ST_RUN);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dstate <= hrg_pkg::STATE_RST;
      seed_cnt <= 8'h00;
      credit <= 5'h00;
    end else begin
      if (comp_valid || make_word) begin
        dstate <= next_dstate; // see (R7)
      end
      if (comp_valid && state == hrg_pkg::ST_SEED && !seed_done) begin
        seed_cnt <= seed_cnt + 8'h01; // see (R9)
      end
      if (make_word) begin
        credit <= credit - need + {4'h0, comp_valid}; // see (R6)
      end else if (run_bit && !credit_full) begin
        credit <= credit + 5'h01;
      end
    end
  end

  assign acc = wide_mode ? out_fn : {8'h00, out_fn[7:0]}; // see (R8)
  assign acc_wide = wide_mode;

  ////////////////////////////////////////
  // Sequencing: test, seed, run, fail.

  always_comb begin
    next_state = state;
    unique case (state)
      hrg_pkg::ST_TEST: begin
        if (test_passed) begin
          next_state = hrg_pkg::ST_SEED; // see (R4)
        end
      end
      hrg_pkg::ST_SEED: begin
        if (seed_done) begin
          next_state = hrg_pkg::ST_RUN; // see (R4)
        end
      end
      hrg_pkg::ST_RUN: begin
        next_state = hrg_pkg::ST_RUN;
      end
      hrg_pkg::ST_FAIL: begin
        next_state = hrg_pkg::ST_FAIL;
      end
    endcase
    if (defect) begin
      next_state = hrg_pkg::ST_FAIL; // see (R1) (R4)
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= hrg_pkg::ST_TEST;
      ready_state <= 1'b0;
    end else begin
      state <= next_state;
      ready_state <= (next_state == hrg_pkg::ST_RUN);
    end
  end

  ////////////////////////////////////////
  // Output buffer and registered consumer port.

  hrg_pkg::hrg_word_t fifo_in;
  hrg_pkg::hrg_word_t fifo_out;
  wire fifo_out_valid;
  wire take = fifo_out_valid && (!rnd_valid || rnd_ready) && !defect;

  assign fifo_in = '{wide: acc_wide, data: acc};

  hrg_fifo #(
    .WIDTH($bits(hrg_pkg::hrg_word_t)),
    .DEPTH(hrg_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .flush(defect),
    .in_data(fifo_in),
    .in_valid(make_word),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(take)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rnd_valid <= 1'b0;
      rnd_data <= '0;
      rnd_wide <= 1'b0;
    end else if (defect) begin
      rnd_valid <= 1'b0; // see (R2) (R12)
      rnd_data <= '0;
    end else if (take) begin
      rnd_valid <= 1'b1; // see (R12)
      rnd_data <= fifo_out.data;
      rnd_wide <= fifo_out.wide;
    end else if (rnd_ready) begin
      rnd_valid <= 1'b0;
    end
  end
endmodule

// [hrg_assertions.sv]
`timescale 1ns/1ns
module hrg_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [hrg_pkg::WORD_W-1:0] rnd_data,
  input wire logic rnd_wide,
  input wire logic rnd_valid,
  input wire logic rnd_ready,
  input wire logic ready_state,
  input wire logic fail_total,
  input wire logic fail_online
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_run_first: assert property (rnd_valid |-> ready_state)
    else $error("word offered outside run state");
  a_total_blocks: assert property (fail_total |-> !rnd_valid)
    else $error("word offered after dead source");
  a_online_blocks: assert property (fail_online |-> !rnd_valid)
    else $error("word offered after online defect");
  a_total_sticky: assert property (fail_total |=> fail_total)
    else $error("dead source flag cleared");
  a_online_sticky: assert property (fail_online |=> fail_online)
    else $error("online defect flag cleared");
  a_narrow_zero: assert property (rnd_valid && !rnd_wide
    |-> rnd_data[15:8] == 8'h00)
    else $error("narrow word has upper byte set");
  a_word_holds: assert property (rnd_valid && !rnd_ready
    |=> (rnd_valid && $stable(rnd_data)) || fail_total || fail_online)
    else $error("offered word changed before acceptance");
  a_fail_stops: assert property ($rose(fail_total)
    |-> ##[0:2] !ready_state)
    else $error("run state kept after dead source");
endmodule
////////////////////////////////////////
bind hrg_top hrg_assertions u_chk (
  .clk(clk), .rst_n(rst_n), .rnd_data(rnd_data), .rnd_wide(rnd_wide),
  .rnd_valid(rnd_valid), .rnd_ready(rnd_ready),
  .ready_state(ready_state), .fail_total(fail_total),
  .fail_online(fail_online)
);

// [hrg_consumer.sv]
`timescale 1ns/1ns
module hrg_consumer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic [hrg_pkg::WORD_W-1:0] rnd_data,
  input wire logic rnd_wide,
  input wire logic rnd_valid,
  output logic rnd_ready,
  output int word_count,
  output logic [hrg_pkg::WORD_W-1:0] last_data,
  output logic last_wide
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rnd_ready <= 1'b0;
      word_count <= 0;
      last_data <= 16'h0000;
      last_wide <= 1'b0;
    end else begin
      rnd_ready <= !stall;
      if (rnd_valid && rnd_ready) begin
        word_count <= word_count + 1;
        last_data <= rnd_data;
        last_wide <= rnd_wide;
      end
    end
  end
endmodule

// [hrg_top_tb.sv]
`timescale 1ns/1ns
module hrg_top_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic raw_bit = 1'b0;
  logic raw_strobe = 1'b0;
  logic wide_mode = 1'b0;
  logic stall = 1'b0;
  logic [15:0] rd;
  logic [15:0] ld;
  logic rw, rv, rr, rs, ft, fo, lw;
  logic [15:0] lfsr = 16'hace1;
  int nw;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;
  always #4 clk = ~clk;
  hrg_top dut (.clk(clk), .rst_n(rst_n), .raw_bit(raw_bit),
    .raw_strobe(raw_strobe), .wide_mode(wide_mode), .rnd_data(rd),
    .rnd_wide(rw), .rnd_valid(rv), .rnd_ready(rr),
    .ready_state(rs), .fail_total(ft), .fail_online(fo));
  hrg_consumer cons (.clk(clk), .rst_n(rst_n), .stall(stall),
    .rnd_data(rd), .rnd_wide(rw), .rnd_valid(rv), .rnd_ready(rr),
    .word_count(nw), .last_data(ld), .last_wide(lw));
  ////////////////////////////////////////
  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Kind 0 gives good bits, 1 a stuck source, 2 a biased source.
  // The strobe idles low, so a reset never sees a false rising edge.
  task automatic feed(input int n, input int k);
    for (int i = 0; i < n; i++) begin
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      raw_bit = (k == 0) ? lfsr[0] : (k == 1) ? 1'b1 : (i % 4 != 3);
      repeat (3) @(posedge clk);
      #1 raw_strobe = 1'b1;
      repeat (3) @(posedge clk);
      #1 raw_strobe = 1'b0;
    end
  endtask
  task automatic bring_up();
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    @(posedge clk);
    #1 chk({rv, rs, ft, fo}, 16'h0);
    feed(250, 0);
    chk({rv, rs}, 16'h0);
    for (int i = 0; i < 900 && rs !== 1'b1; i++) feed(1, 0);
    chk({rs, ft, fo}, 16'h4);
  endtask
  task automatic t_words();
    int n0;
    stall = 1'b1;
    n0 = nw;
    feed(200, 0);
    chk({nw == n0, rv}, 16'h3);
    stall = 1'b0;
    @(posedge clk);
    for (int i = 0; i < 40 && rv === 1'b1; i++) @(posedge clk);
    #1 chk({nw > n0, rv}, 16'h2);
    chk({ld[15:8], 7'h0, lw}, 16'h0);
    wide_mode = 1'b1;
    feed(300, 0);
    chk(16'(lw), 16'h1);
    $display("words done");
  endtask
  task automatic t_stuck();
    int n0;
    feed(40, 1);
    feed(2, 0);
    n0 = nw;
    chk({ft, rs, rv}, 16'h4);
    feed(20, 0);
    chk(16'(nw - n0), 16'h0);
    $display("stuck done");
  endtask
  task automatic t_online();
    bring_up();
    feed(520, 2);
    chk({fo, ft, rv}, 16'h4);
    $display("online done");
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    bring_up();
    $display("startup done");
    t_words();
    t_stuck();
    t_online();
    conclude();
  end
endmodule
